/* File: dv/spi_host_model.sv */
`timescale 1ns/1ps
// ------------
// Host master
// ------------
module spi_host_model (
	input  wire logic core_clk, // Bench clock
	output logic      cs_n,     // Select, low
	output logic      sclk,     // Shift clock
	output logic      si,       // Host data out
	input  wire logic so_w,     // Resolved device data
	input  wire logic so_oe     // Device drive enable
);
	logic oe_seen;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
		oe_seen = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wait_clk

	// Half link period of 40 ns is 8 core clocks
	task automatic xfer(input logic [31:0] tx, input int nbits,
			output logic [31:0] rx);
		rx = '0;
		@(posedge core_clk);
		cs_n <= 1'b0;
		wait_clk(8);
		oe_seen = so_oe;
		for (int k = 0; k < nbits; k++) begin
			sclk <= 1'b1;
			si <= tx[31];
			tx = {tx[30:0], tx[31]};
			wait_clk(8);
			rx = {rx[30:0], so_w};
			sclk <= 1'b0;
			wait_clk(8);
		end
		cs_n <= 1'b1;
		si <= ~si;
		wait_clk(8);
	endtask : xfer
endmodule : spi_host_model

/* File: dv/testbench.sv */
`include "spi_flags_defs.svh"
`timescale 1ns/1ps
module testbench;
	typedef struct {
		logic rw; logic [5:0] addr; logic [23:0] data;
		int nbits; logic bad; logic [23:0] old;
	} row_t;
	localparam logic [23:0] TEST_V = 24'h00_5A5A; // Arbitrary content
	logic                   core_clk = 1'b0;
	logic                   reset = 1'b1;
	logic                   cs_n, sclk, si, so, so_oe, int_n, so_last;
	logic [8:0]             ev_in = '0;
	logic [23:0]            event_reg, ev_e, ev_b, cfg_e;
	logic [`CFG_COUNT*24-1:0] cfg_flat;
	logic [31:0]            w, rx;
	int                     n_fail = 0;
	int                     check_count = 0;
	wire                    so_w = so_oe ? so : ~so_last;
	row_t rows [15] = '{
		'{1, `CFG_BASE, 24'h00_A5C3, 32, 0, 24'h00_0000},
		'{1, `CFG_BASE, 24'h00_3C5A, 32, 0, 24'h00_A5C3},
		'{1, `TEST_ADDR, 24'h00_FFFF, 32, 0, TEST_V},
		'{1, 6'h10, 24'h00_7777, 32, 0, 24'h00_0000},
		'{1, `EVT_ADDR, 24'h00_4444, 32, 0, 24'h00_0000},
		'{0, `TEST_ADDR, 24'h00_0000, 32, 0, TEST_V},
		'{0, 6'h05, 24'h00_0000, 32, 0, 24'h00_0000},
		'{0, `EVT_ADDR, 24'h00_0000, 32, 0, 24'h00_0001},
		'{1, `CFG_BASE, 24'h00_1111, 32, 1, 24'h00_3C5A},
		'{1, `CFG_BASE, 24'h00_2222, 31, 0, 24'h00_0000},
		'{1, `CFG_BASE, 24'h00_2222, 33, 0, 24'h00_0000},
		'{1, `CFG_BASE, 24'h00_3333, 0, 0, 24'h00_0000},
		'{0, `CFG_BASE, 24'h00_0000, 32, 0, 24'h00_3C5A},
		'{0, `EVT_ADDR, 24'h00_0000, 32, 0, 24'h00_0006},
		'{0, `EVT_ADDR, 24'h00_0000, 32, 0, 24'h00_0000}};

	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (so_oe === 1'b1) so_last <= so;

	spi_host_model i_spi_host_model (.core_clk(core_clk), .cs_n(cs_n),
		.sclk(sclk), .si(si), .so_w(so_w), .so_oe(so_oe));
	spi_write_status_flags #(.TEST_VALUE(TEST_V)) i_spi_write_status_flags (
		.core_clk(core_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
		.si(si), .so(so), .so_oe(so_oe), .int_n(int_n),
		.soft_reset_req(ev_in[0]), .switch_change_evt(ev_in[1]),
		.heat_warning_evt(ev_in[2]), .heat_shutdown_evt(ev_in[3]),
		.heat_clear_evt(ev_in[4]), .supply_high_evt(ev_in[5]),
		.supply_low_evt(ev_in[6]), .checksum_done_evt(ev_in[7]),
		.config_check_failure_evt(ev_in[8]), .event_reg(event_reg),
		.cfg_flat(cfg_flat));

	// ------------
	// Helpers
	// ------------
	task automatic check(input logic [31:0] seen, exp, input string m);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s %h vs %h", $time, m, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] exp_rx(logic [23:0] ev, logic [23:0] d);
		logic [31:0] f;
		f = {ev[0], ev[1], ev[2], ev[3], 1'b0, |ev[6:4], |ev[10:7], d, 1'b0};
		f[0] = ~^f[31:1];
		return f;
	endfunction : exp_rx

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	// ------------
	// Tests
	// ------------
	initial begin
		#400us;
		n_fail++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		ev_e = `EVT_RESET;
		cfg_e = '0;
		check(event_reg, ev_e, "reset event");
		check(int_n, 1'b0, "reset int");
		check(so_oe, 1'b0, "reset drive");
		foreach (rows[i]) begin
			w = {rows[i].rw, rows[i].addr, rows[i].data, 1'b0};
			w[0] = ~^w[31:1] ^ rows[i].bad;
			ev_b = ev_e;
			i_spi_host_model.xfer(w, rows[i].nbits, rx);
			if (rows[i].nbits != 0 && rows[i].nbits != 32)
				ev_e[1] = 1'b1;
			else if (rows[i].nbits == 32 && rows[i].bad)
				ev_e[2] = 1'b1;
			else if (rows[i].nbits == 32 && !rows[i].rw &&
					rows[i].addr == `EVT_ADDR)
				ev_e = '0;
			else if (rows[i].nbits == 32 && rows[i].rw &&
					rows[i].addr == `CFG_BASE)
				cfg_e = rows[i].data;
			if (rows[i].nbits == 32) begin
				w = exp_rx(ev_b, rows[i].old);
				check(rx, w, "frame out");
				check(i_spi_host_model.oe_seen, 1'b1, "drive on");
			end
			check(event_reg, ev_e, "event reg");
			check(cfg_flat[23:0], cfg_e, "config word");
			check(|cfg_flat[`CFG_COUNT*24-1:24], 1'b0, "other config");
			check(int_n, ev_e == 0, "interrupt");
			check(so_oe, 1'b0, "drive off");
			$display("row %0d done", i);
		end
		for (int i = 0; i < 9; i++) begin
			ev_b = '0;
			ev_b[i == 0 ? 0 : i + 2] = 1'b1;
			@(posedge core_clk);
			ev_in[i] <= 1'b1;
			@(posedge core_clk);
			ev_in[i] <= 1'b0;
			repeat (3) @(posedge core_clk);
			check(event_reg, ev_b, "event set");
			check(int_n, 1'b0, "event int");
			w = {1'b0, `EVT_ADDR, 24'h00_0000, 1'b0};
			w[0] = ~^w[31:1];
			i_spi_host_model.xfer(w, 32, rx);
			check(rx, exp_rx(ev_b, ev_b), "event flags");
			check(event_reg, 24'h00_0000, "event clear");
		end
		$display("event tests done");
		reset <= 1'b1;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		check(event_reg, `EVT_RESET, "second reset");
		check(cfg_flat[23:0], 24'h00_0000, "config reset");
		check(int_n, 1'b0, "int after reset");
		$display("reset test done");
		conclude();
	end
endmodule : testbench

/* File: hdl/spi_flags_defs.svh */
`ifndef SPI_FLAGS_DEFS_SVH
`define SPI_FLAGS_DEFS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define FRAME_BITS    6'd32
`define CAPTURE_BITS  6'd7
`define CNT_MAX       6'd63
`define RW_BIT        31
`define ADDR_HI       30
`define ADDR_LO       25

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define EVT_ADDR      6'h02
`define CFG_BASE      6'h1A
`define CFG_COUNT     11
`define TEST_ADDR     6'h3F

// ----------------------------------------------------------------
// Event register bit positions and reset value
// ----------------------------------------------------------------
`define EV_RESET      0
`define EV_LEN        1
`define EV_PAR        2
`define EV_SWITCH     3
`define EV_HEAT_WARN  4
`define EV_HEAT_SHUT  5
`define EV_HEAT_CLR   6
`define EV_SUP_HIGH   7
`define EV_SUP_LOW    8
`define EV_CHECKSUM   9
`define EV_CFG_FAIL   10
`define EVT_RESET     24'h00_0001

`endif

/* File: hdl/spi_flags_pkg.sv */
package spi_flags_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_FRAME = 2'b10
	} link_state_t;
	typedef logic [23:0] reg_word_t;
endpackage : spi_flags_pkg

/* File: hdl/spi_write_status_flags.sv */
// Notes on behaviour
// - Write frame returns status flags first, then the register's old content (all zeros for the event register).
// - Old content is captured once bit 25 (address end) has arrived.
// - New data commits at frame end only if address valid, no errors.
// - Invalid write drops its data; target register stays unchanged.
// - Bit 0 of each frame, both directions, is a parity bit.
// - Write to the test register changes nothing but returns its content.
// - Write to an unmapped address returns all zeros.
// - Status flags go out on every frame, mirrored from the event register.
// - Reading the event register clears it and the flags at select rise.
// - Reset-seen flag sets after any reset, hardware or software.
// - Not exactly 32 bits: length error flag, interrupt low, data invalid.
// - A select with no clock edges raises no length error.
// - Odd parity checked; even count of ones drops data, flags, interrupt.
// - Switch-change flag sets when any switch crosses its threshold.
// - Spare flag position always reads zero.
// - Thermal flag sets on heat warning or shutdown, or their clearing.
// - Other-event flag sets on supply, checksum or config-check events.
// - Bit 31 direction (1 write), 6-bit address, data 24..1, parity 0.
// - Select fall enables the output driver and snapshots the flags.
// - Select rise releases interrupt after event read, floats the output.
// - Input sampled on clock fall, output shifted on rise, MSB first.
`include "spi_flags_defs.svh"
`timescale 1ns/1ps
module spi_write_status_flags #(
	parameter int          CFG_COUNT  = `CFG_COUNT,
	parameter logic [23:0] TEST_VALUE = 24'h00_0000 // Arbitrary content
) (
	input  wire logic                  core_clk,            // 200 MHz clock
	input  wire logic                  reset,               // Sync, high
	input  wire logic                  cs_n,                // Chip select pin
	input  wire logic                  sclk,                // Shift clock pin
	input  wire logic                  si,                  // Serial in pin
	output logic                       so,                  // Serial out
	output logic                       so_oe,               // Drive enable
	output logic                       int_n,               // Interrupt, low
	input  wire logic                  soft_reset_req,      // Soft reset pulse
	input  wire logic                  switch_change_evt,   // Threshold cross
	input  wire logic                  heat_warning_evt,    // Warning set
	input  wire logic                  heat_shutdown_evt,   // Shutdown set
	input  wire logic                  heat_clear_evt,      // Heat cleared
	input  wire logic                  supply_high_evt,     // Overvoltage
	input  wire logic                  supply_low_evt,      // Undervoltage
	input  wire logic                  checksum_done_evt,   // Checksum done
	input  wire logic                  config_check_failure_evt, // Cfg fail
	output logic [23:0]                event_reg,           // Event register
	output logic [CFG_COUNT*24-1:0]    cfg_flat             // Config words
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (CFG_COUNT < 1 || CFG_COUNT > 64 - int'(`CFG_BASE)) begin : g_chk
		$error("CFG_COUNT does not fit the address space");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cs_s_r;
	logic [2:0] sclk_s_r;
	logic [1:0] si_s_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cs_s_r   <= 3'h7;
			sclk_s_r <= 3'h0;
			si_s_r   <= 2'h0;
		end else begin
			cs_s_r   <= {cs_s_r[1:0], cs_n};
			sclk_s_r <= {sclk_s_r[1:0], sclk};
			si_s_r   <= {si_s_r[0], si};
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	logic sclk_rise;
	logic si_bit;
	assign cs_fall   = cs_s_r[2] & ~cs_s_r[1];
	assign cs_rise   = ~cs_s_r[2] & cs_s_r[1];
	assign sclk_fall = sclk_s_r[2] & ~sclk_s_r[1];
	assign sclk_rise = ~sclk_s_r[2] & sclk_s_r[1];
	assign si_bit    = si_s_r[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	spi_flags_pkg::link_state_t state_r, state_nxt;
	logic [31:0]               rx_r, rx_nxt;
	logic [31:0]               out_r, out_nxt;
	logic [5:0]                fall_r, fall_nxt;
	logic [5:0]                rise_r, rise_nxt;
	logic                      so_r, so_nxt;
	logic                      so_oe_r, so_oe_nxt;
	logic                      int_n_r, int_n_nxt;
	logic [23:0]               evt_r, evt_nxt;
	spi_flags_pkg::reg_word_t  cfg_r [CFG_COUNT];
	spi_flags_pkg::reg_word_t  cfg_nxt [CFG_COUNT];

	function automatic logic [6:0] flags_of(input logic [23:0] e);
		// Reset, length, parity, switch, spare, thermal, other
		flags_of = {e[`EV_RESET], e[`EV_LEN], e[`EV_PAR], e[`EV_SWITCH],
			1'b0,
			e[`EV_HEAT_WARN] | e[`EV_HEAT_SHUT] | e[`EV_HEAT_CLR],
			|e[`EV_CFG_FAIL:`EV_SUP_HIGH]};
	endfunction : flags_of

	logic [23:0] evt_set;
	always_comb begin
		evt_set = 24'h00_0000;
		evt_set[`EV_RESET]     = soft_reset_req;
		evt_set[`EV_SWITCH]    = switch_change_evt;
		evt_set[`EV_HEAT_WARN] = heat_warning_evt;
		evt_set[`EV_HEAT_SHUT] = heat_shutdown_evt;
		evt_set[`EV_HEAT_CLR]  = heat_clear_evt;
		evt_set[`EV_SUP_HIGH]  = supply_high_evt;
		evt_set[`EV_SUP_LOW]   = supply_low_evt;
		evt_set[`EV_CHECKSUM]  = checksum_done_evt;
		evt_set[`EV_CFG_FAIL]  = config_check_failure_evt;
	end

	// Content returned for an address; unmapped reads zero
	logic [5:0]  cap_addr;
	logic        cap_write;
	logic [23:0] cap_data;
	assign cap_addr  = rx_nxt[5:0];
	assign cap_write = rx_nxt[6];
	always_comb begin
		cap_data = 24'h00_0000;
		if (cap_addr == `EVT_ADDR)
			cap_data = evt_r;
		if (cap_addr == `TEST_ADDR)
			cap_data = TEST_VALUE;
		for (int i = 0; i < CFG_COUNT; i++) begin
			if (cap_addr == `CFG_BASE + 6'(i))
				cap_data = cfg_r[i];
		end
		if (cap_write && cap_addr == `EVT_ADDR)
			cap_data = 24'h00_0000;
	end

	logic len_ok;
	logic par_ok;
	logic frame_ok;
	logic evt_clear;
	assign len_ok   = (fall_r == `FRAME_BITS);
	assign par_ok   = ^rx_r;
	assign frame_ok = len_ok & par_ok;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		rx_nxt    = rx_r;
		out_nxt   = out_r;
		fall_nxt  = fall_r;
		rise_nxt  = rise_r;
		so_nxt    = so_r;
		so_oe_nxt = so_oe_r;
		evt_clear = 1'b0;
		evt_nxt   = evt_r;
		for (int i = 0; i < CFG_COUNT; i++)
			cfg_nxt[i] = cfg_r[i];
		case (state_r)
			spi_flags_pkg::ST_IDLE: begin
				if (cs_fall) begin
					state_nxt = spi_flags_pkg::ST_FRAME;
					fall_nxt  = 6'd0;
					rise_nxt  = 6'd0;
					rx_nxt    = 32'h0000_0000;
					out_nxt   = {flags_of(evt_r), 25'h000_0000};
					so_nxt    = 1'b1;
					so_oe_nxt = 1'b1;
				end
			end
			spi_flags_pkg::ST_FRAME: begin
				if (sclk_fall) begin
					rx_nxt = {rx_r[30:0], si_bit};
					if (fall_r != `CNT_MAX)
						fall_nxt = fall_r + 6'd1;
					if (fall_r == `CAPTURE_BITS - 6'd1)
						out_nxt[24:0] = {cap_data,
							~^{out_r[31:25], cap_data}};
				end
				if (sclk_rise) begin
					so_nxt = (rise_r < `FRAME_BITS) ?
						out_r[5'd31 - rise_r[4:0]] : 1'b0;
					if (rise_r != `CNT_MAX)
						rise_nxt = rise_r + 6'd1;
				end
				if (cs_rise) begin
					state_nxt = spi_flags_pkg::ST_IDLE;
					so_nxt    = 1'b0;
					so_oe_nxt = 1'b0;
					if (fall_r != 6'd0 && !len_ok)
						evt_nxt[`EV_LEN] = 1'b1;
					if (len_ok && !par_ok)
						evt_nxt[`EV_PAR] = 1'b1;
					if (frame_ok && !rx_r[`RW_BIT] &&
						rx_r[`ADDR_HI:`ADDR_LO] == `EVT_ADDR)
						evt_clear = 1'b1;
					for (int i = 0; i < CFG_COUNT; i++) begin
						if (frame_ok && rx_r[`RW_BIT] &&
							rx_r[`ADDR_HI:`ADDR_LO] == `CFG_BASE + 6'(i))
							cfg_nxt[i] = rx_r[24:1];
					end
				end
			end
			default: begin
				state_nxt = spi_flags_pkg::ST_IDLE;
				so_oe_nxt = 1'b0;
			end
		endcase
		// New events win over the clear in the same cycle
		evt_nxt   = (evt_clear ? 24'h00_0000 : evt_nxt) | evt_set;
		int_n_nxt = ~|evt_nxt;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= spi_flags_pkg::ST_IDLE;
			rx_r    <= 32'h0000_0000;
			out_r   <= 32'h0000_0000;
			fall_r  <= 6'd0;
			rise_r  <= 6'd0;
			so_r    <= 1'b0;
			so_oe_r <= 1'b0;
			int_n_r <= 1'b0;
			evt_r   <= `EVT_RESET;
			for (int i = 0; i < CFG_COUNT; i++)
				cfg_r[i] <= 24'h00_0000;
		end else begin
			state_r <= state_nxt;
			rx_r    <= rx_nxt;
			out_r   <= out_nxt;
			fall_r  <= fall_nxt;
			rise_r  <= rise_nxt;
			so_r    <= so_nxt;
			so_oe_r <= so_oe_nxt;
			int_n_r <= int_n_nxt;
			evt_r   <= evt_nxt;
			for (int i = 0; i < CFG_COUNT; i++)
				cfg_r[i] <= cfg_nxt[i];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign so        = so_r;
	assign so_oe     = so_oe_r;
	assign int_n     = int_n_r;
	assign event_reg = evt_r;
	for (genvar g = 0; g < CFG_COUNT; g++) begin : g_cfg
		assign cfg_flat[g*24 +: 24] = cfg_r[g];
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	logic in_frame;
	logic no_set;
	assign in_frame = (state_r == spi_flags_pkg::ST_FRAME);
	assign no_set   = ~|evt_set;

	a_len_error: assert property (in_frame && cs_rise && fall_r != 6'd0 &&
		fall_r != 6'd32 |=> evt_r[`EV_LEN] && !int_n_r)
		else $error("length error not flagged");
	a_no_clock_ok: assert property (in_frame && cs_rise && fall_r == 6'd0 &&
		!evt_r[`EV_LEN] |=> !evt_r[`EV_LEN])
		else $error("length error without clock");
	a_parity_error: assert property (in_frame && cs_rise &&
		fall_r == 6'd32 && !(^rx_r) |=> evt_r[`EV_PAR] && !int_n_r)
		else $error("parity error not flagged");
	a_bad_discard: assert property (in_frame && cs_rise && !frame_ok
		|=> cfg_flat == $past(cfg_flat))
		else $error("invalid frame changed a register");
	a_write_commit: assert property (in_frame && cs_rise && frame_ok &&
		rx_r[31] && rx_r[30:25] == `CFG_BASE
		|=> cfg_flat[23:0] == $past(rx_r[24:1]))
		else $error("valid write not committed");
	a_driver_on: assert property (!in_frame && cs_fall
		|=> so_oe_r && so_r && out_r[31:25] == flags_of($past(evt_r)))
		else $error("select fall did not start frame");
	a_driver_off: assert property (in_frame && cs_rise |=> !so_oe_r)
		else $error("driver not released");
	a_spare_zero: assert property (in_frame && sclk_rise && rise_r == 6'd4
		&& !cs_rise |=> !so_r)
		else $error("spare flag not zero");
	a_event_clear: assert property (in_frame && cs_rise && frame_ok &&
		!rx_r[31] && rx_r[30:25] == `EVT_ADDR && no_set
		|=> evt_r == 24'h00_0000 && int_n_r)
		else $error("event read did not clear");
	a_soft_reset: assert property (soft_reset_req |=> evt_r[`EV_RESET])
		else $error("reset-seen flag missing");
	a_switch_flag: assert property (switch_change_evt
		|=> evt_r[`EV_SWITCH] && !int_n_r)
		else $error("switch flag not set");
	a_msb_first: assert property (in_frame && sclk_rise && rise_r == 6'd0
		&& !cs_rise |=> so_r == $past(out_r[31]))
		else $error("first bit not flag msb");

endmodule : spi_write_status_flags
